// >>> src/srm_cfg.svh
`ifndef SRM_CFG_SVH
`define SRM_CFG_SVH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define SRM_HADDR_W 8
`define SRM_IDX_W 6
`define SRM_IDX_LSB 2
`define SRM_REG_W 8
`define SRM_DATA_W 32

// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define SRM_IDX_IRQ_MASK 6'h0e
`define SRM_IDX_IRQ_STAT 6'h0f
`define SRM_IDX_REG_CTRL 6'h10
`define SRM_IDX_MON_CFG 6'h11

// ----------------------------------------
// field positions
// ----------------------------------------
`define SRM_B_ABYP 7
`define SRM_B_ASET 6
`define SRM_B_DBYP 3
`define SRM_B_DSET 2
`define SRM_B_MOK 5
`define SRM_B_MHR 4
`define SRM_B_VTH_HI 3
`define SRM_B_VTH_LO 0
`define SRM_B_IRQ_LOW 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define SRM_RST_BYP 1'b0
`define SRM_RST_HR 1'b0
`define SRM_RST_VTH 4'h2
`define SRM_RST_MASK 1'b0
`define SRM_RST_HTRANS_NONSEQ 2'h2

`endif

// >>> src/srm_pkg.sv
package srm_pkg;

   // ----------------------------------------
   // latched address phase
   // ----------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic [5:0] idx;
   } srm_req_s;

   // ----------------------------------------
   // supply regulator settings
   // ----------------------------------------
   typedef struct packed {
      logic analog_regulator_bypass;
      logic digital_regulator_bypass;
   } srm_vreg_s;

   // ----------------------------------------
   // monitor threshold settings
   // ----------------------------------------
   typedef struct packed {
      logic threshold_high_range;
      logic [3:0] threshold_select;
   } srm_mon_s;

endpackage : srm_pkg

// >>> src/srm_regs.sv
// How it works
// - bit 7 at 0x10 bypasses analog regulator
// - analog settled bit 6 shows regulator stable
// - analog bypass forces analog settled to one
// - digital bypass bit disables digital regulator
// - digital settled bit shows digital supply stable
// - digital bypass forces digital settled to one
// - bit 5 at 0x11 shows supply above threshold
// - bit 4 picks low or high range
// - bits 3:0 pick threshold code
// - supply low only on falling comparison result
// - never-high result gives no supply low
// - reset to low range, code 0x2
// - monitor idle in power-on and sleep
// - supply low is bit 7 of 0x0e/0x0f
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "srm_cfg.svh"

module srm_regs (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [`SRM_HADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [`SRM_DATA_W-1:0] hwdata,
   output logic [`SRM_DATA_W-1:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // regulator analog side
   input wire logic analog_reg_stable,
   input wire logic digital_reg_stable,
   output logic analog_regulator_bypass,
   output logic digital_regulator_bypass,
   // supply monitor analog side
   input wire logic monitor_active,
   input wire logic supply_cmp_async,
   output logic threshold_high_range,
   output logic [3:0] threshold_select,
   // event towards the interrupt logic
   output logic supply_low_pulse
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   srm_pkg::srm_req_s req_q;
   srm_pkg::srm_req_s req_d;
   srm_pkg::srm_vreg_s vreg_q;
   srm_pkg::srm_vreg_s vreg_d;
   srm_pkg::srm_mon_s mon_q;
   srm_pkg::srm_mon_s mon_d;
   logic mask_q;
   logic mask_d;
   logic stat_q;
   logic stat_d;
   logic ok_q;
   logic ok_d;
   logic ev_q;
   logic ev_d;
   logic [`SRM_DATA_W-1:0] rdata_q;
   logic [`SRM_DATA_W-1:0] rdata_d;

   // ----------------------------------------
   // address phase decode
   // ----------------------------------------
   wire logic cmp_sync;
   wire logic addr_take;
   wire logic [`SRM_IDX_W-1:0] addr_idx;
   wire logic rd_take;
   wire logic hit_mask;
   wire logic hit_stat;
   wire logic hit_ctrl;
   wire logic hit_mon;

   // hsize is not checked: every access is taken as a word
   assign addr_take = hsel & hready & htrans[1];
   assign addr_idx = haddr[`SRM_HADDR_W-1:`SRM_IDX_LSB];
   assign rd_take = addr_take & ~hwrite;
   assign hit_mask = addr_idx == `SRM_IDX_IRQ_MASK;
   assign hit_stat = addr_idx == `SRM_IDX_IRQ_STAT;
   assign hit_ctrl = addr_idx == `SRM_IDX_REG_CTRL;
   assign hit_mon = addr_idx == `SRM_IDX_MON_CFG;

   // ----------------------------------------
   // data phase write strobes
   // ----------------------------------------
   wire logic wr_now;
   wire logic wr_mask;
   wire logic wr_ctrl;
   wire logic wr_mon;

   assign wr_now = req_q.valid & req_q.write;
   assign wr_mask = wr_now & (req_q.idx == `SRM_IDX_IRQ_MASK);
   assign wr_ctrl = wr_now & (req_q.idx == `SRM_IDX_REG_CTRL);
   assign wr_mon = wr_now & (req_q.idx == `SRM_IDX_MON_CFG);

   // ----------------------------------------
   // settled status
   // ----------------------------------------
   // bypass wins, the idle internal regulator is ignored
   wire logic analog_supply_settled;
   wire logic digital_supply_settled;

   assign analog_supply_settled =
      vreg_d.analog_regulator_bypass | analog_reg_stable;
   assign digital_supply_settled =
      vreg_d.digital_regulator_bypass | digital_reg_stable;

   // ----------------------------------------
   // readback images
   // ----------------------------------------
   // status and reserved bits come only from hardware;
   // built from next values, so a read right behind a
   // write on the pipelined bus already sees the new word
   logic [`SRM_REG_W-1:0] img_ctrl;
   logic [`SRM_REG_W-1:0] img_mon;
   logic [`SRM_REG_W-1:0] img_mask;
   logic [`SRM_REG_W-1:0] img_stat;
   wire logic [`SRM_REG_W-1:0] img_sel;

   always_comb begin
      img_ctrl = '0;
      img_ctrl[`SRM_B_ABYP] = vreg_d.analog_regulator_bypass;
      img_ctrl[`SRM_B_ASET] = analog_supply_settled;
      img_ctrl[`SRM_B_DBYP] = vreg_d.digital_regulator_bypass;
      img_ctrl[`SRM_B_DSET] = digital_supply_settled;
   end

   always_comb begin
      img_mon = '0;
      img_mon[`SRM_B_MOK] = ok_q;
      img_mon[`SRM_B_MHR] = mon_d.threshold_high_range;
      img_mon[`SRM_B_VTH_HI:`SRM_B_VTH_LO] =
         mon_d.threshold_select;
   end

   always_comb begin
      img_mask = '0;
      img_mask[`SRM_B_IRQ_LOW] = mask_d;
      img_stat = '0;
      img_stat[`SRM_B_IRQ_LOW] = stat_q;
   end
   assign img_sel = hit_ctrl ? img_ctrl :
                    hit_mon ? img_mon :
                    hit_mask ? img_mask :
                    hit_stat ? img_stat :
                    8'h00;

   // ----------------------------------------
   // read data, captured at the address edge
   // ----------------------------------------
   // zero-wait reads: the word is ready in the data phase
   always_comb begin
      rdata_d = rdata_q;
      if (rd_take) begin
         rdata_d = {24'h00_0000, img_sel};
      end
   end

   // ----------------------------------------
   // address phase latch
   // ----------------------------------------
   // the latch only moves on while the bus is ready
   always_comb begin
      req_d = req_q;
      if (hready) begin
         req_d.valid = addr_take;
         req_d.write = hwrite;
         req_d.idx = addr_idx;
      end
   end

   // ----------------------------------------
   // regulator control writes
   // ----------------------------------------
   always_comb begin
      vreg_d = vreg_q;
      if (wr_ctrl) begin
         vreg_d.analog_regulator_bypass =
            hwdata[`SRM_B_ABYP];
         vreg_d.digital_regulator_bypass =
            hwdata[`SRM_B_DBYP];
      end
   end

   // ----------------------------------------
   // monitor configuration writes
   // ----------------------------------------
   always_comb begin
      mon_d = mon_q;
      if (wr_mon) begin
         mon_d.threshold_high_range =
            hwdata[`SRM_B_MHR];
         mon_d.threshold_select =
            hwdata[`SRM_B_VTH_HI:`SRM_B_VTH_LO];
      end
   end

   // ----------------------------------------
   // interrupt mask write
   // ----------------------------------------
   always_comb begin
      mask_d = mask_q;
      if (wr_mask) begin
         mask_d = hwdata[`SRM_B_IRQ_LOW];
      end
   end

   // ----------------------------------------
   // comparator crossing
   // ----------------------------------------
   // raw comparator may toggle at any time
   srm_sync u_cmp_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in(supply_cmp_async),
      .sync_out(cmp_sync)
   );

   // ----------------------------------------
   // monitor result and falling edge
   // ----------------------------------------
   // result held low while idle, so a wake never looks
   // like a drop and a never-high result gives no event
   // both terms read the synced level, so one fall is one pulse
   wire logic cmp_now_ok;
   wire logic cmp_fell;

   assign cmp_now_ok = monitor_active & cmp_sync;
   assign cmp_fell = monitor_active & ok_q & ~cmp_sync;

   always_comb begin
      ok_d = cmp_now_ok;
      ev_d = cmp_fell;
   end

   // ----------------------------------------
   // interrupt status, cleared by reading it
   // ----------------------------------------
   // a drop in the clearing read's cycle is kept
   wire logic stat_clr;

   assign stat_clr = rd_take & hit_stat;

   always_comb begin
      stat_d = stat_q;
      if (stat_clr) begin
         stat_d = 1'b0;
      end
      if (ev_q & mask_q) begin
         stat_d = 1'b1;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         req_q <= '0;
         vreg_q.analog_regulator_bypass <= `SRM_RST_BYP;
         vreg_q.digital_regulator_bypass <= `SRM_RST_BYP;
         mon_q.threshold_high_range <= `SRM_RST_HR;
         mon_q.threshold_select <= `SRM_RST_VTH;
         mask_q <= `SRM_RST_MASK;
      end else begin
         req_q <= req_d;
         vreg_q <= vreg_d;
         mon_q <= mon_d;
         mask_q <= mask_d;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stat_q <= 1'b0;
         ok_q <= 1'b0;
         ev_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         stat_q <= stat_d;
         ok_q <= ok_d;
         ev_q <= ev_d;
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------
   // bus response flops
   // ----------------------------------------
   // one slave that never stalls and never errors
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------
   // output flops
   // ----------------------------------------
   // mirrors load the next value, so pins move at the write edge
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         analog_regulator_bypass <= `SRM_RST_BYP;
         digital_regulator_bypass <= `SRM_RST_BYP;
         threshold_high_range <= `SRM_RST_HR;
         threshold_select <= `SRM_RST_VTH;
         supply_low_pulse <= 1'b0;
      end else begin
         analog_regulator_bypass <=
            vreg_d.analog_regulator_bypass;
         digital_regulator_bypass <=
            vreg_d.digital_regulator_bypass;
         threshold_high_range <= mon_d.threshold_high_range;
         threshold_select <= mon_d.threshold_select;
         supply_low_pulse <= ev_d;
      end
   end

   assign hrdata = rdata_q;

endmodule : srm_regs

`default_nettype wire

// >>> src/srm_sync.sv
`timescale 1ns/10ps
`default_nettype none

module srm_sync (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // level in and out
   input wire logic async_in,
   output logic sync_out
);

   logic meta_q;

   // ----------------------------------------
   // two-flop crossing
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : srm_sync

`default_nettype wire

// >>> tb/srm_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "srm_cfg.svh"

module srm_regs_chk (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // bus
   input wire logic hsel,
   input wire logic [`SRM_HADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [`SRM_DATA_W-1:0] hwdata,
   input wire logic [`SRM_DATA_W-1:0] hrdata,
   // regulator and monitor side
   input wire logic analog_reg_stable,
   input wire logic digital_reg_stable,
   input wire logic analog_regulator_bypass,
   input wire logic digital_regulator_bypass,
   input wire logic monitor_active,
   input wire logic supply_cmp_async,
   input wire logic threshold_high_range,
   input wire logic [3:0] threshold_select,
   input wire logic supply_low_pulse
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire logic taken = hsel && hready && htrans[1];
   wire logic rd_ctrl = taken && !hwrite && haddr == 8'h40;
   wire logic rd_mon = taken && !hwrite && haddr == 8'h44;
   wire logic wr_ctrl = taken && hwrite && haddr == 8'h40;
   wire logic wr_mon = taken && hwrite && haddr == 8'h44;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   ana_settled_a: assert property (
      rd_ctrl |=> hrdata[6] ==
         (analog_regulator_bypass | $past(analog_reg_stable)))
      else $error("analog settled bit wrong");
   dig_settled_a: assert property (
      rd_ctrl |=> hrdata[2] ==
         (digital_regulator_bypass | $past(digital_reg_stable)))
      else $error("digital settled bit wrong");
   ctrl_rsvd_a: assert property (
      rd_ctrl |=> hrdata[31:8] == 24'h0 && hrdata[5:4] == 2'h0 &&
      hrdata[1:0] == 2'h0)
      else $error("reserved control bits not zero");
   mon_read_a: assert property (
      rd_mon |=> hrdata[7:6] == 2'h0 &&
      hrdata[4:0] == {threshold_high_range, threshold_select})
      else $error("monitor config read wrong");
   ctrl_write_a: assert property (
      wr_ctrl |=> ##1 {analog_regulator_bypass, digital_regulator_bypass}
      == {$past(hwdata[7]), $past(hwdata[3])})
      else $error("bypass outputs not updated");
   mon_write_a: assert property (
      wr_mon |=> ##1 {threshold_high_range, threshold_select} ==
      $past(hwdata[4:0]))
      else $error("threshold outputs not updated");
   reset_value_a: assert property (
      $past(rst) |-> threshold_select == 4'h2 && !threshold_high_range &&
      !analog_regulator_bypass && !digital_regulator_bypass)
      else $error("reset values wrong");
   single_pulse_a: assert property (
      supply_low_pulse |=> !supply_low_pulse)
      else $error("supply low pulse too long");
   pulse_cause_a: assert property (
      supply_low_pulse |-> !$past(supply_cmp_async, 3))
      else $error("supply low without falling result");
   idle_quiet_a: assert property (
      !$past(monitor_active) |-> !supply_low_pulse)
      else $error("supply low while monitor idle");
endmodule : srm_regs_chk

bind srm_regs srm_regs_chk i_chk (
   .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
   .hrdata, .analog_reg_stable, .digital_reg_stable,
   .analog_regulator_bypass, .digital_regulator_bypass, .monitor_active,
   .supply_cmp_async, .threshold_high_range, .threshold_select,
   .supply_low_pulse
);

`default_nettype wire

// >>> tb/test_supply_regulator_monitor_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "srm_cfg.svh"

module test_supply_regulator_monitor_regs;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic sys_clk, rst, hsel, hwrite, hreadyout, hresp;
   logic [`SRM_HADDR_W-1:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [`SRM_DATA_W-1:0] hwdata, hrdata, rdat, exp;
   logic analog_reg_stable, digital_reg_stable, monitor_active;
   logic supply_cmp_async, threshold_high_range, supply_low_pulse;
   logic analog_regulator_bypass, digital_regulator_bypass;
   logic [3:0] threshold_select;
   wire logic hready = hreadyout;
   int fails = 0;
   int n_tests = 0;
   int n_pulse = 0;

   srm_regs i_dut (
      .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
      .hwdata, .hrdata, .hreadyout, .hresp, .analog_reg_stable,
      .digital_reg_stable, .analog_regulator_bypass, .digital_regulator_bypass,
      .monitor_active, .supply_cmp_async, .threshold_high_range,
      .threshold_select, .supply_low_pulse
   );

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // counted off the edge, so never racing the pulse flop
   always @(negedge sys_clk) begin
      if (supply_low_pulse === 1'b1) n_pulse++;
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task chk(input string name, input logic [31:0] seen, input logic [31:0] ex);
      n_tests++;
      if (seen !== ex) begin
         $display("[ERR] %s expected %h seen %h", name, ex, seen);
         fails++;
      end
   endtask : chk

   // single transfer; address held until hready, data phase likewise
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      htrans <= 2'h2;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hready !== 1'b1);
      rdat = hrdata;
   endtask : xfer

   task rd_chk(input string name, input logic [7:0] a,
               input logic [31:0] ex);
      xfer(a, 1'b0, 32'h0000_0000);
      chk(name, rdat, ex);
   endtask : rd_chk

   task do_reset;
      rst <= 1'b1;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
   endtask : do_reset

   task stop_test;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   // whole run is under 2000 cycles
   initial begin
      #50000;
      fails++;
      stop_test;
   end

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
      {analog_reg_stable, digital_reg_stable} = 2'b00;
      {monitor_active, supply_cmp_async} = 2'b00;
      rst = 1'b1;
      do_reset;
      exp = {27'h0, threshold_high_range, threshold_select};
      chk("thr", exp, 32'h0000_0002);
      rd_chk("ctrl", 8'h40, 32'h0000_0000);
      rd_chk("mon", 8'h44, 32'h0000_0002);
      // non-bypass bits written as ones: only the bypass bits may stick
      for (int i = 0; i < 4; i++) begin
         exp = 32'hffff_ff77 | {24'h0, i[1], 3'h0, i[0], 3'h0};
         xfer(8'h40, 1'b1, exp);
         exp = {24'h0, i[1], i[1], 2'h0, i[0], i[0], 2'h0};
         rd_chk("ctrl", 8'h40, exp);
         exp = {30'h0, analog_regulator_bypass, digital_regulator_bypass};
         chk("byp", exp, {30'h0, i[1], i[0]});
      end
      xfer(8'h40, 1'b1, 32'h0000_0000);
      analog_reg_stable <= 1'b1;
      rd_chk("ctrl", 8'h40, 32'h0000_0040);
      analog_reg_stable <= 1'b0;
      digital_reg_stable <= 1'b1;
      rd_chk("ctrl", 8'h40, 32'h0000_0004);
      for (int i = 0; i < 32; i++) begin
         xfer(8'h44, 1'b1, 32'hffff_ffe0 | i);
         exp = {27'h0, i[4:0]};
         rd_chk("mon", 8'h44, exp);
         rdat = {27'h0, threshold_high_range, threshold_select};
         chk("thr", rdat, exp);
      end
      xfer(8'h80, 1'b1, 32'hffff_ffff);
      rdat = {30'h0, hreadyout, hresp};
      chk("resp", rdat, 32'h0000_0002);
      rd_chk("unmapped", 8'h80, 32'h0000_0000);
      do_reset;
      rd_chk("mon", 8'h44, 32'h0000_0002);
      // supply below threshold from the start: never high, no event
      xfer(8'h38, 1'b1, 32'h0000_0080);
      monitor_active <= 1'b1;
      repeat (8) @(posedge sys_clk);
      xfer(8'h44, 1'b1, 32'h0000_0000);
      repeat (8) @(posedge sys_clk);
      chk("pulses", n_pulse, 0);
      rd_chk("mon", 8'h44, 32'h0000_0000);
      supply_cmp_async <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rd_chk("mon", 8'h44, 32'h0000_0020);
      supply_cmp_async <= 1'b0;
      repeat (16) @(posedge sys_clk);
      chk("pulses", n_pulse, 1);
      rd_chk("status", 8'h3c, 32'h0000_0080);
      rd_chk("status", 8'h3c, 32'h0000_0000);
      // idle monitor: result forced low, a fall goes unseen
      supply_cmp_async <= 1'b1;
      repeat (8) @(posedge sys_clk);
      monitor_active <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd_chk("mon", 8'h44, 32'h0000_0000);
      // wake high, then sleep just as the synced fall arrives
      monitor_active <= 1'b1;
      repeat (8) @(posedge sys_clk);
      supply_cmp_async <= 1'b0;
      repeat (2) @(posedge sys_clk);
      monitor_active <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk("pulses", n_pulse, 1);
      rd_chk("status", 8'h3c, 32'h0000_0000);
      stop_test;
   end
endmodule : test_supply_regulator_monitor_regs

`default_nettype wire
